//--- hdl/watchdog_timer.sv
// watchdog/general purpose 16-bit timer with secure clear sequence
// assumes tick_32k is a one-pclk pulse at 32 kHz rate, synchronous to pclk
//
// How it works
// RULE1: normal mode ticks 32k divided 1/16/256
// RULE2: watchdog mode counts on 32k tick
// RULE3: control bit 5 enters watchdog, reset off
// RULE4: watchdog counts down from load value
// RULE5: full load at /256 gives 512 s
// RULE6: zero gives irq if bit1, else reset
// RULE7: service write reloads counter from load
// RULE8: load and control locked in watchdog mode
// RULE9: load and count are 16 bits, count read-only
// RULE10: clear write drops normal pending interrupt
// RULE11: secure mode service must match sequence
// RULE12: sequence is x8+x6+x5+x+1 shift register
// RULE13: software seeds sequence before watchdog entry
// RULE14: matching write steps sequence at reload
// RULE15: mismatch resets at once
// RULE16: zero seed always forces reset
// RULE17: sequence state is never readable
// RULE18: control bit 8 selects count up
// RULE19: control bit 7 enables timer
// RULE20: control bit 6 selects periodic mode
// RULE21: control bit 4 enables secure clear
// RULE22: bits 3-2 prescale, 11 acts as 00
// RULE23: periodic reloads with irq, free-run wraps
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module watchdog_timer
    import wdt_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timebase
    input wire logic tick_32k,
    // system outputs
    output wdt_out_type wdt_out
);
    // ****************************************
    // state
    // ****************************************
    logic [8:0] control_reg;
    logic [15:0] load_reg;
    logic [15:0] count_reg;
    logic [7:0] seq_reg;
    logic [7:0] pre_reg;
    logic irq_reg;
    logic [3:0] rst_cnt_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    logic wr_access, rd_access;
    logic load_sel, count_sel, control_sel, clear_sel, mapped;
    logic wd_mode, locked, enabled, tick, service;
    logic seq_match, seq_fail, expire;
    logic [7:0] pre_last;
    logic [7:0] seq_next;

    function automatic logic [7:0] seq_step(input logic [7:0] s);
        // galois form of x8+x6+x5+x+1: shift left, fold the taps back in on carry out
        seq_step = {s[6:0], 1'b0} ^ (s[7] ? 8'h63 : 8'h00);
    endfunction : seq_step

    // ****************************************
    // bus decode
    // ****************************************
    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign load_sel = paddr == load_off;
    assign count_sel = paddr == count_off;
    assign control_sel = paddr == control_off;
    assign clear_sel = paddr == clear_off;
    assign mapped = load_sel || count_sel || control_sel || clear_sel;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    assign wd_mode = control_reg[watchdog_bit];
    assign locked = wd_mode; // RULE8
    assign enabled = control_reg[enable_bit] || wd_mode; // RULE19
    assign service = wr_access && clear_sel;
    assign seq_next = seq_step(seq_reg); // RULE12
    assign seq_match = pwdata[7:0] == seq_reg;
    // RULE11 RULE15 RULE16
    assign seq_fail = service && wd_mode && control_reg[secure_bit]
                      && (!seq_match || seq_reg == seed_reset);

    // RULE22
    always_comb begin
        case (control_reg[prescale_hi:prescale_lo])
            pre_div16: pre_last = div16_last;
            pre_div256: pre_last = div256_last;
            default: pre_last = div1_last;
        endcase
    end

    // RULE1 RULE2 RULE5
    assign tick = enabled && tick_32k && (pre_reg == pre_last);
    assign expire = tick && wd_mode && (count_reg == 16'h0000 || count_reg == 16'h0001);

    // ****************************************
    // registers written by software
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= control_reset; // RULE3
        end else if (wr_access && control_sel && !locked) begin // RULE8
            control_reg <= pwdata[8:0] & control_mask; // RULE18 RULE20 RULE21
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_reg <= load_reset;
        end else if (wr_access && load_sel && !locked) begin // RULE8
            load_reg <= pwdata[15:0]; // RULE9
        end
    end

    // ****************************************
    // prescaler
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 8'h00;
        end else if (!enabled) begin
            pre_reg <= 8'h00;
        end else if (tick_32k) begin
            pre_reg <= (pre_reg >= pre_last) ? 8'h00 : pre_reg + 8'h01;
        end
    end

    // ****************************************
    // counter
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= count_reset;
        end else if (wr_access && control_sel && !locked && pwdata[watchdog_bit]) begin
            count_reg <= load_reg; // RULE4
        end else if (wr_access && load_sel && !locked) begin
            count_reg <= pwdata[15:0];
        end else if (service && wd_mode && !seq_fail) begin
            count_reg <= load_reg; // RULE7
        end else if (tick) begin
            if (wd_mode) begin
                count_reg <= (count_reg == 16'h0000) ? load_reg : count_reg - 16'h0001; // RULE4
            end else if (control_reg[up_bit]) begin // RULE18
                if (count_reg == 16'hffff && control_reg[periodic_bit]) begin
                    count_reg <= load_reg; // RULE23
                end else begin
                    count_reg <= count_reg + 16'h0001;
                end
            end else if (count_reg == 16'h0000 && control_reg[periodic_bit]) begin // RULE20
                count_reg <= load_reg; // RULE23
            end else begin
                count_reg <= count_reg - 16'h0001; // RULE23
            end
        end
    end

    // ****************************************
    // secure sequence
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_reg <= seed_reset;
        end else if (service && !wd_mode) begin
            seq_reg <= pwdata[7:0]; // RULE13
        end else if (service && control_reg[secure_bit] && !seq_fail) begin
            seq_reg <= seq_next; // RULE14
        end
    end

    // ****************************************
    // interrupt
    // ****************************************
    logic term;
    assign term = tick && !wd_mode && (control_reg[up_bit] ? count_reg == 16'hffff
                                                          : count_reg == 16'h0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else if (term || (expire && control_reg[irq_opt_bit])) begin
            irq_reg <= 1'b1; // RULE6 RULE23
        end else if (service && !wd_mode) begin
            irq_reg <= 1'b0; // RULE10
        end else if (service && wd_mode && !seq_fail) begin
            irq_reg <= 1'b0;
        end
    end

    // ****************************************
    // reset request
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_reg <= 4'h0;
        end else if ((expire && !control_reg[irq_opt_bit]) || seq_fail) begin
            rst_cnt_reg <= 4'(reset_pulse_cycles); // RULE6 RULE15
        end else if (rst_cnt_reg != 4'h0) begin
            rst_cnt_reg <= rst_cnt_reg - 4'h1;
        end
    end

    assign wdt_out.irq = irq_reg;
    assign wdt_out.reset_req = rst_cnt_reg != 4'h0;

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= psel && !penable && !mapped;
            prdata_reg <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    load_off: prdata_reg <= {16'h0000, load_reg};
                    count_off: prdata_reg <= {16'h0000, count_reg}; // RULE9
                    control_off: prdata_reg <= {23'h000000, control_reg};
                    default: prdata_reg <= 32'h00000000; // RULE17
                endcase
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence bad_service_s;
        service && wd_mode && control_reg[secure_bit] && !seq_match;
    endsequence

    control_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        wd_mode |=> wd_mode && $stable(control_reg) && $stable(load_reg)) // RULE8
        else $error("control changed in watchdog mode");
    mismatch_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        bad_service_s |=> wdt_out.reset_req [*4]) // RULE15
        else $error("no reset after bad service");
    zero_seed_a: assert property (@(posedge pclk) disable iff (!presetn)
        service && wd_mode && control_reg[secure_bit] && seq_reg == 8'h00 |=> wdt_out.reset_req) // RULE16
        else $error("zero seed did not reset");
    seq_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        service && wd_mode && control_reg[secure_bit] && !seq_fail
        |=> seq_reg == seq_step($past(seq_reg))) // RULE14
        else $error("sequence not stepped");
    service_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        service && wd_mode && !seq_fail && !tick |=> count_reg == load_reg) // RULE7
        else $error("service did not reload");
    expire_action_a: assert property (@(posedge pclk) disable iff (!presetn)
        expire && !control_reg[irq_opt_bit] |=> wdt_out.reset_req) // RULE6
        else $error("expiry without reset");
    expire_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        expire && control_reg[irq_opt_bit] |=> wdt_out.irq) // RULE6
        else $error("expiry without irq");
    clear_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        service && !wd_mode && !term |=> !wdt_out.irq) // RULE10
        else $error("irq not cleared");
    hold_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
        !enabled && !wr_access |=> $stable(count_reg)) // RULE19
        else $error("counter moved while disabled");

    // ****************************************
    // bus and register assertions
    // ****************************************
    clear_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
        rd_access && clear_sel
        |-> prdata == 32'h00000000)
        else $error("clear register read back nonzero");
    count_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        rd_access && count_sel
        |-> prdata == {16'h0000, $past(count_reg)})
        else $error("count read data wrong");
    count_ro_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        wr_access && count_sel && !tick
        |=> $stable(count_reg))
        else $error("count register took a write");
    load_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        wr_access && load_sel && !locked
        |=> load_reg == $past(pwdata[15:0]))
        else $error("load register not written");
    enter_load_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3 RULE4
        wr_access && control_sel && !locked && pwdata[watchdog_bit]
        |=> wd_mode && count_reg == load_reg)
        else $error("watchdog entry did not load count");

    // ****************************************
    // counter and prescaler assertions
    // ****************************************
    sequence wd_tick_s;
        tick && wd_mode && !service;
    endsequence

    sequence run_tick_s;
        tick && !wd_mode && !wr_access;
    endsequence

    pre_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1 RULE22
        enabled && tick_32k && pre_reg < pre_last
        |=> pre_reg == $past(pre_reg) + 8'h01)
        else $error("prescaler did not advance");
    pre_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
        !enabled
        |=> pre_reg == 8'h00)
        else $error("prescaler ran while disabled");
    count_down_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        wd_tick_s ##0 (count_reg != 16'h0000)
        |=> count_reg == $past(count_reg) - 16'h0001)
        else $error("watchdog count did not step down");
    zero_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        wd_tick_s ##0 (count_reg == 16'h0000)
        |=> count_reg == load_reg)
        else $error("watchdog did not reload at zero");
    count_up_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
        run_tick_s ##0 (control_reg[up_bit] && count_reg != 16'hffff)
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("timer did not count up");
    count_dec_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE18 RULE23
        run_tick_s ##0 (!control_reg[up_bit] && count_reg != 16'h0000)
        |=> count_reg == $past(count_reg) - 16'h0001)
        else $error("timer did not count down");
    periodic_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE20 RULE23
        run_tick_s ##0 (term && control_reg[periodic_bit])
        |=> count_reg == load_reg)
        else $error("periodic timer did not reload");
    free_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE20 RULE23
        run_tick_s ##0 (term && !control_reg[periodic_bit])
        |=> count_reg == ~$past(count_reg))
        else $error("free running timer did not wrap");

    // ****************************************
    // interrupt, reset and sequence assertions
    // ****************************************
    term_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
        term
        |=> wdt_out.irq)
        else $error("terminal count without irq");
    irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        wdt_out.irq && !service
        |=> wdt_out.irq)
        else $error("irq dropped without a clear write");
    irq_source_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6 RULE23
        !wdt_out.irq && !term && !(expire && control_reg[irq_opt_bit])
        |=> !wdt_out.irq)
        else $error("irq raised without an event");
    wd_no_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        wd_mode && !control_reg[irq_opt_bit] && !wdt_out.irq
        |=> !wdt_out.irq)
        else $error("irq raised with irq option clear");
    reset_source_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6 RULE15
        !wdt_out.reset_req && !expire && !seq_fail
        |=> !wdt_out.reset_req)
        else $error("reset request without a cause");
    quiet_normal_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        !wd_mode && !wdt_out.reset_req
        |=> !wdt_out.reset_req)
        else $error("reset request in normal mode");
    seed_store_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        service && !wd_mode
        |=> seq_reg == $past(pwdata[7:0]))
        else $error("seed not stored");
    seq_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        !service
        |=> $stable(seq_reg))
        else $error("sequence moved without a service write");
endmodule : watchdog_timer

//--- pkg/wdt_pkg.sv
// package for the watchdog/general timer: register map, control fields, timing
// assumes an apb slave on a 100 MHz pclk with a 32 kHz tick input
package wdt_pkg;
    // ****************************************
    // register map (byte addresses, own choice)
    // ****************************************
    localparam logic [11:0] load_off = 12'h000;
    localparam logic [11:0] count_off = 12'h004;
    localparam logic [11:0] control_off = 12'h008;
    localparam logic [11:0] clear_off = 12'h00c;
    // ****************************************
    // control fields
    // ****************************************
    localparam int up_bit = 8;
    localparam int enable_bit = 7;
    localparam int periodic_bit = 6;
    localparam int watchdog_bit = 5;
    localparam int secure_bit = 4;
    localparam int prescale_hi = 3;
    localparam int prescale_lo = 2;
    localparam int irq_opt_bit = 1;
    localparam logic [8:0] control_mask = 9'h1fe;
    localparam logic [8:0] control_reset = 9'h000;
    localparam logic [15:0] load_reset = 16'h0000;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam logic [7:0] seed_reset = 8'h00;
    // ****************************************
    // prescaler and reset pulse constants
    // ****************************************
    localparam logic [7:0] div1_last = 8'h00;
    localparam logic [7:0] div16_last = 8'h0f;
    localparam logic [7:0] div256_last = 8'hff;
    localparam logic [1:0] pre_div16 = 2'b01;
    localparam logic [1:0] pre_div256 = 2'b10;
    localparam int reset_pulse_ns = 100;
    localparam int clk_period_ns = 10;
    localparam int reset_pulse_cycles = reset_pulse_ns / clk_period_ns;

    typedef struct packed {
        logic reset_req;
        logic irq;
    } wdt_out_type;
endpackage : wdt_pkg

//--- test/testbench.sv
// self-checking bench for the watchdog timer: apb master tasks, tick pulses, checks
// assumes watchdog_timer and wdt_pkg as delivered; the bench drives every port itself
`timescale 1ns/1ps
module testbench;
    import wdt_pkg::*;
    // ****************************************
    // signals, clock and design
    // ****************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic tick_32k = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [31:0] d;
    logic pready;
    logic pslverr;
    logic er;
    logic seen_rst;
    logic [7:0] s;
    logic [15:0] c0;
    wdt_out_type wdt_out;
    int mismatches = 0;
    int checks = 0;
    int run;
    int last_run;
    logic [11:0] offs [4] = '{load_off, count_off, control_off, clear_off};
    logic [31:0] cfg [6] = '{32'h080, 32'h084, 32'h088, 32'h08c, 32'h180, 32'h000};
    int tk [6] = '{5, 16, 256, 5, 5, 5};
    logic [15:0] dl [6] = '{16'hfffb, 16'hffff, 16'hffff, 16'hfffb, 16'h0005, 16'h0000};
    always #5 pclk = ~pclk;
    watchdog_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tick_32k(tick_32k), .wdt_out(wdt_out));
    // ****************************************
    // reset request monitor: sticky flag and pulse length
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_rst <= 1'b0;
            run <= 0;
            last_run <= 0;
        end else if (wdt_out.reset_req === 1'b1) begin
            seen_rst <= 1'b1;
            run <= run + 1;
        end else if (run != 0) begin
            last_run <= run;
            run <= 0;
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task ticks(input int n);
        repeat (n) begin
            @(posedge pclk);
            tick_32k <= 1'b1;
            @(posedge pclk);
            tick_32k <= 1'b0;
        end
    endtask : ticks
    task do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    function automatic logic [7:0] step(input logic [7:0] v);
        return {v[6:0], 1'b0} ^ (v[7] ? 8'h63 : 8'h00);
    endfunction : step
    task give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(72930));
        do_reset();
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, offs[i], 32'h0);
            chk("reset value", rd, 32'h0);
            chk("mapped no error", {31'h0, er}, 32'h0);
        end
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", {31'h0, er}, 32'h1);
        d = $urandom | 32'h8000;
        apb(1'b1, load_off, d);
        apb(1'b0, load_off, 32'h0);
        chk("load width", rd, {16'h0, d[15:0]});
        apb(1'b1, count_off, $urandom);
        apb(1'b0, count_off, 32'h0);
        chk("count read only", rd, {16'h0, d[15:0]});
        d = $urandom & 32'hffffffdf;
        apb(1'b1, control_off, d);
        apb(1'b0, control_off, 32'h0);
        chk("control fields", rd, d & {23'h0, control_mask});
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, control_off, cfg[i]);
            apb(1'b0, count_off, 32'h0);
            c0 = rd[15:0];
            ticks(tk[i]);
            apb(1'b0, count_off, 32'h0);
            chk("count step", rd, {16'h0, 16'(c0 + dl[i])});
        end
        apb(1'b1, load_off, 32'h4);
        apb(1'b1, control_off, 32'h0c0);
        ticks(6);
        chk("periodic irq", {31'h0, wdt_out.irq}, 32'h1);
        apb(1'b1, clear_off, $urandom);
        @(posedge pclk);
        chk("irq cleared", {31'h0, wdt_out.irq}, 32'h0);
        apb(1'b1, load_off, 32'h2);
        apb(1'b1, control_off, 32'h080);
        ticks(3);
        apb(1'b0, count_off, 32'h0);
        chk("free wrap", rd, 32'hffff);
        // secure watchdog: seed, lock, matching services, then a mismatch
        do_reset();
        s = 8'h01 + 8'($urandom % 255);
        apb(1'b1, clear_off, {24'h0, s});
        apb(1'b0, clear_off, 32'h0);
        chk("sequence hidden", rd, 32'h0);
        apb(1'b1, load_off, 32'h100);
        apb(1'b1, control_off, 32'h0b0);
        apb(1'b1, control_off, 32'h0);
        apb(1'b1, load_off, 32'h5);
        apb(1'b0, control_off, 32'h0);
        chk("control locked", rd, 32'h0b0);
        apb(1'b0, load_off, 32'h0);
        chk("load locked", rd, 32'h100);
        for (int i = 0; i < 3; i++) begin
            ticks(3);
            apb(1'b0, count_off, 32'h0);
            chk("watchdog count", rd, 32'h0fd);
            apb(1'b1, clear_off, {24'h0, s});
            apb(1'b0, count_off, 32'h0);
            chk("service reload", rd, 32'h100);
            s = step(s);
            chk("no reset on match", {31'h0, seen_rst}, 32'h0);
        end
        apb(1'b1, clear_off, {24'h0, s ^ 8'h5a});
        repeat (15) @(posedge pclk);
        chk("mismatch reset", {31'h0, seen_rst}, 32'h1);
        chk("reset pulse", 32'(last_run), 32'(reset_pulse_cycles));
        // expiry with and without the interrupt option
        for (int opt = 1; opt >= 0; opt--) begin
            do_reset();
            apb(1'b1, load_off, 32'h3);
            apb(1'b1, control_off, 32'h020 | 32'(opt << irq_opt_bit));
            ticks(5);
            chk("expiry irq", {31'h0, wdt_out.irq}, 32'(opt));
            chk("expiry reset", {31'h0, seen_rst}, 32'(1 - opt));
        end
        do_reset();
        apb(1'b1, load_off, 32'h100);
        apb(1'b1, control_off, 32'h030);
        apb(1'b1, clear_off, 32'h0);
        repeat (3) @(posedge pclk);
        chk("zero seed reset", {31'h0, seen_rst}, 32'h1);
        give_verdict();
    end
endmodule : testbench
